// [hdl/iras_params.svh]
`ifndef IRAS_PARAMS_SVH
`define IRAS_PARAMS_SVH

// bus address of the target, seven bits
`define IRAS_SLAVE_ADDR   7'h69
// configuration memory layout
`define IRAS_SEL_ADDR     8'h40
`define IRAS_SEL_MASK     8'h03
`define IRAS_WORD_BASE    8'h10
`define IRAS_WORD_BYTES   8'h06
`define IRAS_MEM_RESET    8'h00
// write buffer shape: pointer byte plus data byte
`define IRAS_FIFO_WIDTH   16
`define IRAS_FIFO_DEPTH   16
// clock rate and output data hold after the serial clock falls
`define IRAS_CLK_MHZ      40
`define IRAS_HOLD_NS      200
`define IRAS_HOLD_CYC     ((`IRAS_HOLD_NS * `IRAS_CLK_MHZ + 999) / 1000)

`endif

// [hdl/iras_pkg.sv]
package iras_pkg;

    // protocol phases of the target engine
    typedef enum logic [3:0] {
        IRAS_IDLE,
        IRAS_DEVADR,
        IRAS_ACK_DEV,
        IRAS_REGADR,
        IRAS_ACK_REG,
        IRAS_WDATA,
        IRAS_ACK_DATA,
        IRAS_TX,
        IRAS_RACK
    } iras_state_t;

    typedef logic [7:0] iras_byte_t;

endpackage : iras_pkg

// [hdl/iras_fifo.sv]
`timescale 1ns/1ps

module iras_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_idx;
    logic [AW-1:0]    rd_idx;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // honest flags straight from the fill count
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_idx];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_idx] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule : iras_fifo

// [hdl/iras_slave.sv]
// What this block does
// - controller sends full register address; device acks
// - store following byte there and ack it
// - multi-byte write: ack each byte until stop, up to 16 buffered bytes per transfer; later bytes are nacked
// - pointer advances one after each written byte
// - direction bit one means read request
// - pointer holds one past last accessed location
// - on read address, ack then send pointed byte
// - master nack plus stop ends driving data
// - restart after register address: no store, keep pointer
// - master ack increments pointer, sends next byte
// - pointer wraps from ffh to 00h
// - select byte at 40h, two low bits choose word
// - answer configurable seven-bit address, default 69h
// - target only, up to 100 kbit/s
`timescale 1ns/1ps
`include "iras_params.svh"

module iras_slave #(
    parameter logic [6:0] SLAVE_ADDR = `IRAS_SLAVE_ADDR
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE,
    output logic [1:0]       WORD_SEL,
    output logic [47:0]      FREQ_WORD
);

    localparam logic [3:0] HOLD_CYC = 4'(`IRAS_HOLD_CYC);

    // byte address of one byte of a frequency word
    function automatic logic [7:0] word_addr(input logic [1:0] sel, input logic [2:0] idx);
        word_addr = `IRAS_WORD_BASE + 8'(sel) * `IRAS_WORD_BYTES + 8'(idx);
    endfunction : word_addr

    // pointer step with natural wrap at the top of the map
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        ptr_step = p + 8'h01;
    endfunction : ptr_step

    iras_pkg::iras_byte_t  mem [256];
    iras_pkg::iras_state_t state;

    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_d;
    logic        sda_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;

    logic [7:0]  ptr;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic [3:0]  bit_cnt;
    logic        rw;
    logic        mack;
    logic        tx_load;
    logic        drive_want;
    logic [3:0]  hold_cnt;
    logic        commit;

    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic        fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic [1:0]  next_sel;
    logic [47:0] next_freq;

    // two-stage synchronisers for the bus pins
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
        end else begin
            scl_sync <= {scl_sync[0], SCL_I};
            sda_sync <= {sda_sync[0], SDA_I};
        end
    end

    // previous synchronised levels for edge detection
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end

    // bus events: clock edges, start and stop while clock high
    assign scl_rise = scl_sync[1] && !scl_d;
    assign scl_fall = !scl_sync[1] && scl_d;
    assign start_ev = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign stop_ev  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

    // received data byte travels with its pointer into the write buffer
    assign fifo_in_data = {ptr, rx_shift};
    assign fifo_in_valid = (state == iras_pkg::IRAS_WDATA) && scl_fall && (bit_cnt == 4'h8);

    // protocol engine; only ever answers, never starts a transfer
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state      <= iras_pkg::IRAS_IDLE;
            bit_cnt    <= 4'h0;
            rx_shift   <= 8'h00;
            tx_shift   <= 8'h00;
            rw         <= 1'b0;
            mack       <= 1'b0;
            tx_load    <= 1'b0;
            drive_want <= 1'b0;
            ptr        <= 8'h00;
        end else if (start_ev) begin
            // a restart commits the buffered bytes and drops any partial byte, pointer stays
            state      <= iras_pkg::IRAS_DEVADR;
            bit_cnt    <= 4'h0;
            tx_load    <= 1'b0;
            drive_want <= 1'b0;
        end else if (stop_ev) begin
            state      <= iras_pkg::IRAS_IDLE;
            tx_load    <= 1'b0;
            drive_want <= 1'b0;
        end else begin
            case (state)
                iras_pkg::IRAS_IDLE: begin
                    drive_want <= 1'b0;
                end
                iras_pkg::IRAS_DEVADR, iras_pkg::IRAS_REGADR, iras_pkg::IRAS_WDATA: begin
                    if (scl_rise && bit_cnt != 4'h8) begin
                        rx_shift <= {rx_shift[6:0], sda_sync[1]};
                        bit_cnt  <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == iras_pkg::IRAS_DEVADR) begin
                            if (rx_shift[7:1] == SLAVE_ADDR) begin
                                rw         <= rx_shift[0];
                                drive_want <= 1'b1;
                                state      <= iras_pkg::IRAS_ACK_DEV;
                            end else begin
                                state <= iras_pkg::IRAS_IDLE;
                            end
                        end else if (state == iras_pkg::IRAS_REGADR) begin
                            ptr        <= rx_shift;
                            drive_want <= 1'b1;
                            state      <= iras_pkg::IRAS_ACK_REG;
                        end else begin
                            // full buffer refuses the byte with a nack
                            if (fifo_in_ready) begin
                                ptr        <= ptr_step(ptr);
                                drive_want <= 1'b1;
                            end
                            mack  <= fifo_in_ready;
                            state <= iras_pkg::IRAS_ACK_DATA;
                        end
                    end
                end
                iras_pkg::IRAS_ACK_DEV: begin
                    if (scl_fall) begin
                        drive_want <= 1'b0;
                        if (rw) begin
                            tx_load <= 1'b1;
                            state   <= iras_pkg::IRAS_TX;
                        end else begin
                            state <= iras_pkg::IRAS_REGADR;
                        end
                    end
                end
                iras_pkg::IRAS_ACK_REG: begin
                    if (scl_fall) begin
                        drive_want <= 1'b0;
                        state      <= iras_pkg::IRAS_WDATA;
                    end
                end
                iras_pkg::IRAS_ACK_DATA: begin
                    if (scl_fall) begin
                        drive_want <= 1'b0;
                        // keep taking bytes until stop arrives; a refused byte sends the engine idle
                        state <= mack ? iras_pkg::IRAS_WDATA : iras_pkg::IRAS_IDLE;
                    end
                end
                iras_pkg::IRAS_TX: begin
                    if (tx_load) begin
                        // fetch waits until committed writes have landed
                        if (!fifo_out_valid) begin
                            tx_shift   <= mem[ptr];
                            drive_want <= !mem[ptr][7];
                            ptr        <= ptr_step(ptr);
                            bit_cnt    <= 4'h0;
                            tx_load    <= 1'b0;
                        end
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            drive_want <= 1'b0;
                            state      <= iras_pkg::IRAS_RACK;
                        end else begin
                            tx_shift   <= {tx_shift[6:0], 1'b0};
                            drive_want <= !tx_shift[6];
                            bit_cnt    <= bit_cnt + 4'h1;
                        end
                    end
                end
                iras_pkg::IRAS_RACK: begin
                    if (scl_rise) begin
                        mack <= !sda_sync[1];
                    end else if (scl_fall) begin
                        if (mack) begin
                            tx_load <= 1'b1;
                            state   <= iras_pkg::IRAS_TX;
                        end else begin
                            state <= iras_pkg::IRAS_IDLE;
                        end
                    end
                end
                default: begin
                    state      <= iras_pkg::IRAS_IDLE;
                    drive_want <= 1'b0;
                end
            endcase
        end
    end

    // data hold timer: line changes only a hold time after the clock falls
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hold_cnt <= 4'h0;
        end else if (scl_fall) begin
            hold_cnt <= HOLD_CYC;
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1;
        end
    end

    // open-drain driver: output level is always low, enable pulls the line
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SDA_O  <= 1'b0;
            SDA_OE <= 1'b0;
        end else begin
            SDA_O <= 1'b0;
            if (start_ev || stop_ev) begin
                SDA_OE <= 1'b0;
            end else if (hold_cnt == 4'h0 && !scl_fall) begin
                SDA_OE <= drive_want;
            end
        end
    end

    // commit window: buffered bytes land only after stop or restart
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            commit <= 1'b0;
        end else if (start_ev || stop_ev) begin
            commit <= 1'b1;
        end else if (!fifo_out_valid) begin
            commit <= 1'b0;
        end
    end

    // write buffer between the serial side and the configuration memory
    iras_fifo #(
        .WIDTH (`IRAS_FIFO_WIDTH),
        .DEPTH (`IRAS_FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .sys_rst   (SYS_RST),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (commit),
        .out_data  (fifo_out_data)
    );

    // configuration memory; select byte keeps only its two low bits
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `IRAS_MEM_RESET;
            end
        end else if (fifo_out_valid && commit) begin
            if (fifo_out_data[15:8] == `IRAS_SEL_ADDR) begin
                mem[fifo_out_data[15:8]] <= fifo_out_data[7:0] & `IRAS_SEL_MASK;
            end else begin
                mem[fifo_out_data[15:8]] <= fifo_out_data[7:0];
            end
        end
    end

    // active word assembled from six consecutive bytes, first byte on top
    always_comb begin
        next_sel  = mem[`IRAS_SEL_ADDR][1:0];
        next_freq = '0;
        for (int i = 0; i < 6; i++) begin
            next_freq[47 - 8*i -: 8] = mem[word_addr(next_sel, 3'(i))];
        end
    end

    // registered word select and active frequency word
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            WORD_SEL  <= 2'h0;
            FREQ_WORD <= 48'h0;
        end else begin
            WORD_SEL  <= next_sel;
            FREQ_WORD <= next_freq;
        end
    end

endmodule : iras_slave

// [tb/iras_slave_checker.sv]
`timescale 1ns/1ps
`include "iras_params.svh"
module iras_slave_checker #(
    parameter logic [6:0] SLAVE_ADDR = `IRAS_SLAVE_ADDR
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    input  wire logic        SDA_O,
    input  wire logic        SDA_OE,
    input  wire logic [1:0]  WORD_SEL,
    input  wire logic [47:0] FREQ_WORD
);
    logic       scl_d;
    logic       sda_d;
    logic       first;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic [7:0] low_cnt;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // delayed pins and cycles spent with the clock low
    always_ff @(posedge CLK) begin
        scl_d   <= SCL_I;
        sda_d   <= SDA_I;
        low_cnt <= SCL_I ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    end

    // follow the first byte after a start condition
    always_ff @(posedge CLK) begin
        if (SYS_RST || (SCL_I && scl_d && sda_d && !SDA_I)) begin
            first <= !SYS_RST;
            bits  <= 4'h0;
        end else if (SCL_I && !scl_d) begin
            shreg <= {shreg[6:0], SDA_I};
            bits  <= bits + 4'h1;
            first <= first && bits != 4'h8;
        end
    end

    property p_match;
        first && bits == 4'h8 && shreg[7:1] == SLAVE_ADDR && low_cnt == 8'h14 |-> SDA_OE;
    endproperty
    a_match: assert property (p_match) else $error("own address not acknowledged");
    property p_foreign;
        first && bits == 4'h8 && shreg[7:1] != SLAVE_ADDR |-> !SDA_OE;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address driven");
    property p_stop_rel;
        SCL_I && scl_d && !sda_d && SDA_I |-> !SDA_OE [*8];
    endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("line held after stop");
    property p_drive_low; SDA_OE |-> !SDA_O; endproperty
    a_drive_low: assert property (p_drive_low) else $error("driven level not low");
    property p_rise_low; $rose(SDA_OE) |-> !SCL_I; endproperty
    a_rise_low: assert property (p_rise_low) else $error("drive began with clock high");
    property p_hold; $changed(SDA_OE) && !SCL_I |-> low_cnt >= 8'h08; endproperty
    a_hold: assert property (p_hold) else $error("output hold too short");
    property p_stand; SCL_I && scl_d && $past(SDA_OE) |-> SDA_OE; endproperty
    a_stand: assert property (p_stand) else $error("drive dropped with clock high");
    property p_sel; $changed(WORD_SEL) |-> SCL_I; endproperty
    a_sel: assert property (p_sel) else $error("select changed mid bit");
    property p_word; $changed(FREQ_WORD) |-> SCL_I && $past(SCL_I, 4); endproperty
    a_word: assert property (p_word) else $error("word changed mid bit");

    c_ack: cover property ($rose(SDA_OE));
    c_stop: cover property (SCL_I && scl_d && !sda_d && SDA_I);
    c_sel: cover property ($changed(WORD_SEL));
endmodule : iras_slave_checker

bind iras_slave iras_slave_checker #(.SLAVE_ADDR(SLAVE_ADDR)) u_chk (
    .CLK(CLK), .SYS_RST(SYS_RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
    .SDA_OE(SDA_OE), .WORD_SEL(WORD_SEL), .FREQ_WORD(FREQ_WORD));

// [tb/iras_bus_master.sv]
`timescale 1ns/1ps
module iras_bus_master #(
    parameter int T_LOW  = 188,
    parameter int T_HIGH = 160
) (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_low,
    output logic            res_stb,
    output logic [8:0]      res_val
);
    // bus idle, both lines released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
        res_stb = 1'b0;
        res_val = 9'h000;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    // one clock pulse: data set while low, line sampled mid-high
    task automatic pulse(input logic v, output logic r);
        wait_n(4);
        sda_low = !v;
        wait_n(T_LOW - 4);
        scl = 1'b1;
        wait_n(T_HIGH / 2);
        r = sda;
        wait_n(T_HIGH / 2);
        scl = 1'b0;
    endtask : pulse

    // start or repeated start, clock left low
    task automatic start;
        wait_n(4);
        sda_low = 1'b0;
        wait_n(T_LOW);
        scl = 1'b1;
        wait_n(T_HIGH);
        sda_low = 1'b1;
        wait_n(T_HIGH);
        scl = 1'b0;
    endtask : start

    // stop condition, then bus free time
    task automatic stop;
        wait_n(4);
        sda_low = 1'b1;
        wait_n(T_LOW);
        scl = 1'b1;
        wait_n(T_HIGH);
        sda_low = 1'b0;
        wait_n(T_LOW);
    endtask : stop

    // byte out msb first, acknowledge level reported
    task automatic send_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) pulse(b[i], r);
        pulse(1'b1, r);
        res_val = {8'h00, r};
        res_stb = ~res_stb;
    endtask : send_byte

    // byte in, then low to continue or high to end
    task automatic recv_byte(input logic last);
        logic [7:0] v;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, r);
            v[i] = r;
        end
        res_val = {1'b1, v};
        res_stb = ~res_stb;
        pulse(last, r);
    endtask : recv_byte
endmodule : iras_bus_master

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "iras_params.svh"
module tb_top;
    localparam logic [7:0] ad_w = {`IRAS_SLAVE_ADDR, 1'b0};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        scl;
    logic        m_low;
    logic        sda_o;
    logic        sda_oe;
    logic [1:0]  word_sel;
    logic [47:0] freq_word;
    logic        res_stb;
    logic [8:0]  res_val;
    logic [8:0]  exp_q[$];
    logic [7:0]  d[6];
    logic [47:0] w;
    logic [7:0]  s;
    logic [6:0]  a;
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    wire         sda = ~((sda_oe & ~sda_o) | m_low); // open drain, pull-up

    always #12.5 clk = ~clk;

    iras_slave uut (.CLK(clk), .SYS_RST(sys_rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .WORD_SEL(word_sel), .FREQ_WORD(freq_word));
    iras_bus_master mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low),
        .res_stb(res_stb), .res_val(res_val));

    task automatic tally(input logic ok, input logic [47:0] e, input logic [47:0] g);
        checks++;
        if (!ok) begin
            err_total++;
            $display("Error t=%0t exp %h got %h", $time, e, g);
        end
    endtask : tally
    task automatic cmp_ack(input logic [8:0] e, input logic [8:0] g);
        tally(g === e, 48'(e), 48'(g));
    endtask : cmp_ack
    task automatic cmp_byte(input logic [8:0] e, input logic [8:0] g);
        tally(g === e, 48'(e), 48'(g));
    endtask : cmp_byte
    task automatic cmp_out(input logic [47:0] e, input logic [47:0] g);
        tally(g === e, e, g);
    endtask : cmp_out
    // byte out, noting the acknowledge owed
    task automatic wb(input logic [7:0] b, input logic nak);
        exp_q.push_back({8'h00, nak});
        mst.send_byte(b);
    endtask : wb
    // byte in, noting the value owed
    task automatic rb(input logic [7:0] e, input logic last);
        exp_q.push_back({1'b1, e});
        mst.recv_byte(last);
    endtask : rb
    task automatic give_verdict;
        $display("Checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // match each bus result with the oldest note
    always @(res_stb) begin
        if (!sys_rst) begin
            if (exp_q.size() == 0) tally(1'b0, 48'h0, 48'(res_val));
            else if (exp_q[0][8]) cmp_byte(exp_q.pop_front(), res_val);
            else cmp_ack(exp_q.pop_front(), res_val);
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 99000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        s = 8'($urandom(86));
        a = 7'($urandom);
        if (a == `IRAS_SLAVE_ADDR) a = ~a;
        foreach (d[i]) d[i] = 8'($urandom);
        w = {d[0], d[1], d[2], d[3], d[4], d[5]};
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        // whole word 0, committed at stop
        mst.start();
        wb(ad_w, 1'b0);
        wb(8'h10, 1'b0);
        foreach (d[i]) wb(d[i], 1'b0);
        mst.stop();
        cmp_out(w, freq_word);
        // select byte with random reserved bits
        mst.start();
        wb(ad_w, 1'b0);
        wb(8'h40, 1'b0);
        wb(s, 1'b0);
        mst.stop();
        cmp_out(48'(s[1:0]), 48'(word_sel));
        cmp_out(s[1:0] == 2'h0 ? w : 48'h0, freq_word);
        // random read: address write, restart, one byte
        mst.start();
        wb(ad_w, 1'b0);
        wb(8'h13, 1'b0);
        mst.start();
        wb(ad_w | 8'h01, 1'b0);
        rb(d[3], 1'b1);
        mst.stop();
        // foreign address ignored, then current address read
        mst.start();
        wb({a, 1'b0}, 1'b1);
        mst.stop();
        mst.start();
        wb(ad_w | 8'h01, 1'b0);
        rb(d[4], 1'b1);
        mst.stop();
        // writes and reads across the top location
        mst.start();
        wb(ad_w, 1'b0);
        wb(8'hff, 1'b0);
        wb(s, 1'b0);
        wb(~s, 1'b0);
        mst.start();
        wb(ad_w, 1'b0);
        wb(8'hff, 1'b0);
        mst.start();
        wb(ad_w | 8'h01, 1'b0);
        rb(s, 1'b0);
        rb(~s, 1'b1);
        mst.stop();
        if (exp_q.size() != 0) tally(1'b0, 48'(exp_q.size()), 48'h0);
        give_verdict();
    end
endmodule : tb_top
